// [hdl/pfsg_guard.sv]
// program flash segment guard: access checker for fetch, read, program, erase
`timescale 1ns/1ps
`default_nettype none
module pfsg_guard #(
    parameter int ADDR_W = pfsg_pkg::ADDR_W,
    parameter int LIMIT_W = pfsg_pkg::LIMIT_W,
    parameter logic [pfsg_pkg::PAGE_W-1:0] LAST_PAGE = pfsg_pkg::DEF_LAST_PAGE,
    parameter logic [pfsg_pkg::PAGE_W-1:0] PART_PAGES = pfsg_pkg::DEF_PART_PAGES
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic reqValid,
    input wire logic [1:0] reqKind,
    input wire logic [ADDR_W-1:0] reqAddr,
    input wire logic [ADDR_W-1:0] srcAddr,
    input wire logic [1:0] bootCodeProt,
    input wire logic bootWriteProt,
    input wire logic [1:0] generalCodeProt,
    input wire logic generalWriteProt,
    input wire logic [1:0] configCodeProt,
    input wire logic configWriteProt,
    input wire logic [LIMIT_W-1:0] bootLimitPages,
    input wire logic altVectorEn,
    input wire logic [1:0] partMode,
    input wire logic activePart2,
    output logic rspValid,
    output logic rspAllow,
    output logic [2:0] rspReason,
    output logic [1:0] rspSegment
);
    localparam int PAGE_W = pfsg_pkg::PAGE_W;

    typedef struct packed {
        logic valid;
        logic allow;
        logic [2:0] reason;
        logic [1:0] segment;
    } pfsg_state_t;

    pfsg_state_t state_r;
    pfsg_state_t state_nxt;

    // ------------------------------------------------------------
    // address split into partition and page
    // ------------------------------------------------------------
    logic dualOn;
    logic [PAGE_W-1:0] tgtPageAbs;
    logic [PAGE_W-1:0] srcPageAbs;
    logic [PAGE_W-1:0] tgtPage;
    logic [PAGE_W-1:0] srcPage;
    logic tgtPart2;
    logic srcPart2;
    logic tgtUpperHalf;
    logic [PAGE_W-1:0] mapLast;

    always_comb begin
        dualOn = partMode != 2'(pfsg_pkg::PART_SINGLE);
        tgtPageAbs = reqAddr[ADDR_W-1:pfsg_pkg::PAGE_SHIFT];
        srcPageAbs = srcAddr[ADDR_W-1:pfsg_pkg::PAGE_SHIFT];
        tgtUpperHalf = reqAddr[pfsg_pkg::HALF_SHIFT];
        // dual mode: partitions are equal halves, each with own map
        tgtPart2 = dualOn && (tgtPageAbs >= PART_PAGES);
        srcPart2 = dualOn && (srcPageAbs >= PART_PAGES);
        tgtPage = tgtPart2 ? tgtPageAbs - PART_PAGES : tgtPageAbs;
        srcPage = srcPart2 ? srcPageAbs - PART_PAGES : srcPageAbs;
        mapLast = dualOn ? PART_PAGES - PAGE_W'(1) : LAST_PAGE;
    end

    // ------------------------------------------------------------
    // segment lookup for target and for the requesting code
    // ------------------------------------------------------------
    logic [1:0] tgtSeg;
    logic [1:0] srcSeg;
    logic tgtAlt;
    logic srcAlt;

    pfsg_segment_map #(.PAGE_W(PAGE_W), .LIMIT_W(LIMIT_W)) u_tgtMap (
        .page(tgtPage),
        .lastPage(mapLast),
        .bootLimitPages(bootLimitPages),
        .altVectorEn(altVectorEn),
        .segment(tgtSeg),
        .isAltPage(tgtAlt)
    );

    pfsg_segment_map #(.PAGE_W(PAGE_W), .LIMIT_W(LIMIT_W)) u_srcMap (
        .page(srcPage),
        .lastPage(mapLast),
        .bootLimitPages(bootLimitPages),
        .altVectorEn(altVectorEn),
        .segment(srcSeg),
        .isAltPage(srcAlt)
    );

    // ------------------------------------------------------------
    // request kind and partition mode decode
    // ------------------------------------------------------------
    logic kindRead;
    logic kindProg;
    logic kindErase;
    logic protOn;
    logic privOn;
    logic vecWpAny;
    logic tgtIsConfig;
    logic tgtIsNone;
    logic altUnusable;

    always_comb begin
        kindRead = reqKind == 2'(pfsg_pkg::ACC_READ);
        kindProg = reqKind == 2'(pfsg_pkg::ACC_PROG);
        kindErase = reqKind == 2'(pfsg_pkg::ACC_ERASE);
        // protected and privileged share the partition 1 lock
        protOn = partMode == 2'(pfsg_pkg::PART_PROTECTED)
                 || partMode == 2'(pfsg_pkg::PART_PRIVILEGED);
        privOn = partMode == 2'(pfsg_pkg::PART_PRIVILEGED);
        // either write lock is enough to freeze the vector page
        vecWpAny = bootWriteProt || generalWriteProt;
        tgtIsConfig = tgtSeg == 2'(pfsg_pkg::SEG_CONFIG);
        tgtIsNone = tgtSeg == 2'(pfsg_pkg::SEG_NONE);
        // only the upper half is lost; the lower half holds the table
        altUnusable = tgtAlt && tgtUpperHalf;
    end

    // ------------------------------------------------------------
    // access decision
    // ------------------------------------------------------------
    logic isWrite;
    logic isFetch;
    logic bootOn;
    logic tgtIvt;
    logic [1:0] effSeg;
    logic effWp;
    logic effCp;
    logic srcBoot;
    logic srcGeneral;
    logic sameSeg;
    logic allow;
    logic [2:0] why;

    always_comb begin
        isWrite = reqKind == 2'(pfsg_pkg::ACC_PROG) || reqKind == 2'(pfsg_pkg::ACC_ERASE);
        isFetch = reqKind == 2'(pfsg_pkg::ACC_FETCH);
        bootOn = bootLimitPages >= pfsg_pkg::LIMIT_ONE_PAGE;
        tgtIvt = tgtPage == pfsg_pkg::IVT_PAGE;
        // vector page follows boot security unless boot is off
        effSeg = tgtSeg;
        if (tgtIvt && !bootOn) begin
            effSeg = 2'(pfsg_pkg::SEG_GENERAL);
        end
        srcBoot = srcSeg == 2'(pfsg_pkg::SEG_BOOT) && !srcAlt;
        srcGeneral = srcSeg == 2'(pfsg_pkg::SEG_GENERAL);
        sameSeg = (srcSeg == effSeg) && (srcPart2 == tgtPart2);
        case (effSeg)
            2'(pfsg_pkg::SEG_BOOT): begin
                effWp = bootWriteProt;
                effCp = bootCodeProt != 2'h3;
            end
            2'(pfsg_pkg::SEG_GENERAL): begin
                effWp = generalWriteProt;
                effCp = generalCodeProt != 2'h3;
            end
            2'(pfsg_pkg::SEG_CONFIG): begin
                effWp = configWriteProt;
                effCp = configCodeProt != 2'h3;
            end
            default: begin
                effWp = 1'b1;
                effCp = 1'b1;
            end
        endcase
        // code-protected segments refuse reads from code in other segments; boot code may still read any of them but config
        allow = 1'b1;
        why = pfsg_pkg::WHY_OK;
        if (tgtIsNone) begin
            allow = 1'b0;
            why = pfsg_pkg::WHY_UNUSABLE;
        end else if (altUnusable) begin
            allow = 1'b0;
            why = pfsg_pkg::WHY_UNUSABLE;
        end else if (isFetch) begin
            if (tgtPart2 != activePart2 && dualOn) begin
                allow = 1'b0;
                why = pfsg_pkg::WHY_PARTITION;
            end else if (tgtAlt) begin
                allow = 1'b1;
            end
        end else if (kindRead) begin
            // boot code reads freely except config-protected region
            if (effCp && !sameSeg && !(srcBoot && effSeg != 2'(pfsg_pkg::SEG_CONFIG))) begin
                allow = 1'b0;
                why = pfsg_pkg::WHY_CODE_PROT;
            end else if (privOn && srcGeneral
                         && effSeg == 2'(pfsg_pkg::SEG_BOOT)) begin
                allow = 1'b0;
                why = pfsg_pkg::WHY_CODE_PROT;
            end
        end else begin
            if (protOn && !tgtPart2) begin
                allow = 1'b0;
                why = pfsg_pkg::WHY_PARTITION;
            end else if (tgtAlt && srcBoot) begin
                allow = 1'b1;
            end else if (tgtIvt && vecWpAny) begin
                allow = 1'b0;
                why = pfsg_pkg::WHY_VECTOR;
            end else if (tgtIsConfig && configWriteProt && kindErase) begin
                allow = 1'b0;
                why = pfsg_pkg::WHY_CONFIG_ERASE;
            end else if (tgtIsConfig && kindProg) begin
                // config words change only while their lock is open
                allow = !configWriteProt;
                why = configWriteProt ? pfsg_pkg::WHY_WRITE_PROT : pfsg_pkg::WHY_OK;
            end else if (tgtAlt) begin
                allow = 1'b1;
            end else if (effWp) begin
                allow = 1'b0;
                why = pfsg_pkg::WHY_WRITE_PROT;
            end else if (privOn
                         && ((srcGeneral && effSeg == 2'(pfsg_pkg::SEG_BOOT))
                             || (srcBoot && effSeg == 2'(pfsg_pkg::SEG_GENERAL)
                                 && tgtPart2 == srcPart2))) begin
                allow = 1'b0;
                why = pfsg_pkg::WHY_CODE_PROT;
            end else if (effCp && srcGeneral && effSeg == 2'(pfsg_pkg::SEG_BOOT)) begin
                // least privileged code may not alter protected boot
                allow = 1'b0;
                why = pfsg_pkg::WHY_CODE_PROT;
            end
        end
    end

    // ------------------------------------------------------------
    // registered answer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        state_nxt.valid = reqValid;
        if (reqValid) begin
            state_nxt.allow = allow;
            state_nxt.reason = why;
            state_nxt.segment = effSeg;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign rspValid = state_r.valid;
    assign rspAllow = state_r.allow;
    assign rspReason = state_r.reason;
    assign rspSegment = state_r.segment;
endmodule
`default_nettype wire

// [include/pfsg_pkg.sv]
// shared constants and types for the program flash segment guard
package pfsg_pkg;
    localparam int ADDR_W = 24;
    localparam int PAGE_IW = 512;
    localparam int PAGE_SHIFT = 10;
    localparam int LIMIT_W = 13;
    localparam int PAGE_W = ADDR_W - PAGE_SHIFT;
    localparam int HALF_PAGE_IW = 256;
    localparam int HALF_SHIFT = 9;
    localparam logic [LIMIT_W-1:0] LIMIT_ONE_PAGE = 13'h0001;
    localparam logic [LIMIT_W-1:0] LIMIT_TWO_PAGE = 13'h0002;
    localparam logic [PAGE_W-1:0] IVT_PAGE = 14'h0000;
    localparam logic [PAGE_W-1:0] DEF_LAST_PAGE = 14'h002B;
    localparam logic [PAGE_W-1:0] DEF_PART_PAGES = 14'h0016;

    typedef enum logic [1:0] {
        ACC_FETCH,
        ACC_READ,
        ACC_PROG,
        ACC_ERASE
    } pfsg_acc_t;

    typedef enum logic [1:0] {
        PART_SINGLE,
        PART_DUAL,
        PART_PROTECTED,
        PART_PRIVILEGED
    } pfsg_part_t;

    typedef enum logic [1:0] {
        SEG_BOOT,
        SEG_GENERAL,
        SEG_CONFIG,
        SEG_NONE
    } pfsg_seg_t;

    // deny reason codes
    localparam logic [2:0] WHY_OK = 3'h0;
    localparam logic [2:0] WHY_WRITE_PROT = 3'h1;
    localparam logic [2:0] WHY_CODE_PROT = 3'h2;
    localparam logic [2:0] WHY_VECTOR = 3'h3;
    localparam logic [2:0] WHY_PARTITION = 3'h4;
    localparam logic [2:0] WHY_UNUSABLE = 3'h5;
    localparam logic [2:0] WHY_CONFIG_ERASE = 3'h6;
endpackage

// [hdl/pfsg_segment_map.sv]
// page-to-segment classifier for one partition
`timescale 1ns/1ps
`default_nettype none
module pfsg_segment_map #(
    parameter int PAGE_W = pfsg_pkg::PAGE_W,
    parameter int LIMIT_W = pfsg_pkg::LIMIT_W
) (
    input wire logic [PAGE_W-1:0] page,
    input wire logic [PAGE_W-1:0] lastPage,
    input wire logic [LIMIT_W-1:0] bootLimitPages,
    input wire logic altVectorEn,
    output logic [1:0] segment,
    output logic isAltPage
);
    logic [PAGE_W-1:0] limitExt;
    logic bootOn;

    always_comb begin
        limitExt = PAGE_W'(bootLimitPages);
        // alternate table forces at least two boot pages when boot is on (limit of one page)
        if (altVectorEn && bootLimitPages < pfsg_pkg::LIMIT_TWO_PAGE) begin
            limitExt = PAGE_W'(pfsg_pkg::LIMIT_TWO_PAGE);
        end
        bootOn = bootLimitPages >= pfsg_pkg::LIMIT_ONE_PAGE;
        isAltPage = altVectorEn && (page == limitExt - PAGE_W'(1));
        if (page > lastPage) begin
            segment = 2'(pfsg_pkg::SEG_NONE);
        end else if (page == lastPage) begin
            // top page shares general code and config words
            segment = 2'(pfsg_pkg::SEG_CONFIG);
        end else if (bootOn && page < limitExt) begin
            segment = 2'(pfsg_pkg::SEG_BOOT);
        end else begin
            segment = 2'(pfsg_pkg::SEG_GENERAL);
        end
    end
endmodule
`default_nettype wire

// [testbench/pfsg_guard_props.sv]
// checker: timing and access relations at the guard ports
`timescale 1ns/1ps
`default_nettype none
module pfsg_guard_chk #(
    parameter logic [13:0] LAST_PAGE = pfsg_pkg::DEF_LAST_PAGE,
    parameter logic [13:0] PART_PAGES = pfsg_pkg::DEF_PART_PAGES
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic reqValid,
    input wire logic [1:0] reqKind,
    input wire logic [23:0] reqAddr,
    input wire logic [23:0] srcAddr,
    input wire logic [1:0] bootCodeProt,
    input wire logic bootWriteProt,
    input wire logic [1:0] generalCodeProt,
    input wire logic generalWriteProt,
    input wire logic [1:0] configCodeProt,
    input wire logic configWriteProt,
    input wire logic [12:0] bootLimitPages,
    input wire logic altVectorEn,
    input wire logic [1:0] partMode,
    input wire logic activePart2,
    input wire logic rspValid,
    input wire logic rspAllow,
    input wire logic [2:0] rspReason,
    input wire logic [1:0] rspSegment
);
    wire logic [13:0] pg = reqAddr[23:10];
    wire logic [13:0] lim = {1'b0, bootLimitPages};
    wire logic single = reqValid && partMode == 2'h0;
    wire logic wr = reqValid && reqKind[1];
    wire logic altHit = altVectorEn && lim >= 14'h0002 && pg == lim - 14'h0001;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    rsp_pulse_a: assert property (reqValid |=> rspValid)
        else $error("request without answer pulse");
    rsp_quiet_a: assert property (!reqValid |=> !rspValid)
        else $error("answer pulse without request");
    ivt_write_a: assert property (wr && single && pg == 14'h0000 && (bootWriteProt || generalWriteProt) |=> !rspAllow)
        else $error("vector table write allowed");
    alt_upper_a: assert property (single && altHit && reqAddr[9] |=> !rspAllow && rspReason == 3'h5)
        else $error("unusable half not refused");
    cfg_erase_a: assert property (single && reqKind == 2'h3 && pg == LAST_PAGE && configWriteProt |=> !rspAllow)
        else $error("last page erase allowed");
    part1_write_a: assert property (wr && partMode[1] && pg < PART_PAGES |=> !rspAllow)
        else $error("partition one write allowed");
    inactive_fetch_a: assert property (reqValid && reqKind == 2'h0 && partMode != 2'h0 && (pg < PART_PAGES) == activePart2 |=> !rspAllow)
        else $error("fetch from inactive partition allowed");
    alt_write_a: assert property (wr && single && altHit && !reqAddr[9] && srcAddr[23:10] < lim - 14'h0001 |=> rspAllow)
        else $error("boot code refused on last boot page");
    boot_seg_a: assert property (single && !altVectorEn && pg < lim |=> rspSegment == 2'h0)
        else $error("boot page not classed boot");
    cfg_seg_a: assert property (single && pg == LAST_PAGE |=> rspSegment == 2'h2)
        else $error("last page not classed config");
endmodule
bind pfsg_guard pfsg_guard_chk #(.LAST_PAGE(LAST_PAGE), .PART_PAGES(PART_PAGES)) u_chk (.*);
`default_nettype wire

// [testbench/pfsg_requester.sv]
// model of the fetch path and programming sequencer
`timescale 1ns/1ps
`default_nettype none
module pfsg_requester (
    input wire logic clk_sys,
    input wire logic rspValid,
    input wire logic rspAllow,
    output logic reqValid,
    output logic [1:0] reqKind,
    output logic [23:0] reqAddr,
    output logic [23:0] srcAddr
);
    int commits;
    logic late;
    initial begin
        reqValid = 1'b0;
        reqKind = 2'h0;
        reqAddr = 24'h000000;
        srcAddr = 24'h000000;
        commits = 0;
        late = 1'b0;
    end
    task automatic issue(input logic [1:0] k, input logic [23:0] a, input logic [23:0] s);
        @(posedge clk_sys);
        reqValid <= 1'b1;
        reqKind <= k;
        reqAddr <= a;
        srcAddr <= s;
        @(posedge clk_sys);
        reqValid <= 1'b0;
        // released address shows junk, not the last value
        reqAddr <= ~a;
        #1;
        late = (rspValid !== 1'b1);
        // a refused write leaves flash untouched
        if (rspAllow === 1'b1 && k[1]) commits++;
    endtask
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// bench for the segment guard: table of cases, then reset in mid-run
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin failures++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module tb_top;
    typedef struct packed {
        logic [1:0] k;
        logic [13:0] pg;
        logic hi;
        logic [13:0] sp;
        logic [2:0] wp;
        logic [1:0] ccp;
        logic [12:0] lim;
        logic alt;
        logic [1:0] mode;
        logic act;
        logic allow;
        logic [2:0] why;
        logic [1:0] seg;
    } pfsg_row_t;
    logic clk_sys, rst_b, bootWriteProt, generalWriteProt, configWriteProt, altVectorEn, activePart2;
    logic [1:0] configCodeProt, partMode, reqKind, rspSegment;
    logic [12:0] bootLimitPages;
    logic reqValid, rspValid, rspAllow;
    logic [23:0] reqAddr, srcAddr;
    logic [2:0] rspReason;
    int failures, samples_checked, expCommits;
    pfsg_row_t rows[17];
    pfsg_row_t r;
    pfsg_requester req (.clk_sys(clk_sys), .rspValid(rspValid), .rspAllow(rspAllow),
        .reqValid(reqValid), .reqKind(reqKind), .reqAddr(reqAddr), .srcAddr(srcAddr));
    // code protect of boot and general left open; config one is swept
    pfsg_guard dut (.clk_sys(clk_sys), .rst_b(rst_b), .reqValid(reqValid), .reqKind(reqKind),
        .reqAddr(reqAddr), .srcAddr(srcAddr), .bootCodeProt(2'h3), .bootWriteProt(bootWriteProt),
        .generalCodeProt(2'h3), .generalWriteProt(generalWriteProt),
        .configCodeProt(configCodeProt), .configWriteProt(configWriteProt),
        .bootLimitPages(bootLimitPages), .altVectorEn(altVectorEn), .partMode(partMode),
        .activePart2(activePart2), .rspValid(rspValid), .rspAllow(rspAllow),
        .rspReason(rspReason), .rspSegment(rspSegment));
    task automatic print_verdict;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // ----------------
    // cases, then reset
    // ----------------
    initial begin
        rows = '{
            '{2'h0,14'h0001,1'h0,14'h0000,3'h0,2'h3,13'h0002,1'h0,2'h0,1'h0,1'h1,3'h0,2'h0},
            '{2'h1,14'h0005,1'h0,14'h0000,3'h0,2'h3,13'h0002,1'h0,2'h0,1'h0,1'h1,3'h0,2'h1},
            '{2'h1,14'h002B,1'h0,14'h0000,3'h0,2'h3,13'h0002,1'h0,2'h0,1'h0,1'h1,3'h0,2'h2},
            '{2'h2,14'h0000,1'h0,14'h0005,3'h4,2'h3,13'h0002,1'h0,2'h0,1'h0,1'h0,3'h7,2'h3},
            '{2'h3,14'h0000,1'h0,14'h0000,3'h2,2'h3,13'h0000,1'h0,2'h0,1'h0,1'h0,3'h7,2'h3},
            '{2'h2,14'h0002,1'h0,14'h0001,3'h4,2'h3,13'h0003,1'h1,2'h0,1'h0,1'h1,3'h0,2'h3},
            '{2'h1,14'h0002,1'h1,14'h0001,3'h0,2'h3,13'h0003,1'h1,2'h0,1'h0,1'h0,3'h5,2'h3},
            '{2'h3,14'h002B,1'h0,14'h0000,3'h1,2'h3,13'h0002,1'h0,2'h0,1'h0,1'h0,3'h7,2'h3},
            '{2'h2,14'h0005,1'h0,14'h0005,3'h2,2'h3,13'h0002,1'h0,2'h0,1'h0,1'h0,3'h1,2'h1},
            '{2'h1,14'h002B,1'h0,14'h0000,3'h0,2'h0,13'h0002,1'h0,2'h0,1'h0,1'h0,3'h2,2'h2},
            '{2'h0,14'h0017,1'h0,14'h0001,3'h0,2'h3,13'h0001,1'h0,2'h1,1'h0,1'h0,3'h4,2'h3},
            '{2'h1,14'h0017,1'h0,14'h0001,3'h0,2'h3,13'h0001,1'h0,2'h1,1'h0,1'h1,3'h0,2'h3},
            '{2'h2,14'h0003,1'h0,14'h0018,3'h0,2'h3,13'h0001,1'h0,2'h2,1'h1,1'h0,3'h7,2'h3},
            '{2'h1,14'h0001,1'h0,14'h0005,3'h0,2'h3,13'h0002,1'h0,2'h3,1'h0,1'h0,3'h7,2'h3},
            '{2'h2,14'h0005,1'h0,14'h0000,3'h1,2'h3,13'h0002,1'h0,2'h0,1'h0,1'h1,3'h0,2'h1},
            '{2'h1,14'h0001,1'h1,14'h0000,3'h0,2'h3,13'h0001,1'h1,2'h0,1'h0,1'h0,3'h5,2'h3},
            '{2'h1,14'h0001,1'h0,14'h0000,3'h0,2'h3,13'h0001,1'h0,2'h0,1'h0,1'h1,3'h0,2'h1}};
        {bootWriteProt, generalWriteProt, configWriteProt, altVectorEn, activePart2} = 5'h00;
        configCodeProt = 2'h3;
        partMode = 2'h0;
        bootLimitPages = 13'h0002;
        failures = 0;
        samples_checked = 0;
        expCommits = 0;
        rst_b = 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            r = rows[i];
            @(posedge clk_sys);
            {bootWriteProt, generalWriteProt, configWriteProt} <= r.wp;
            configCodeProt <= r.ccp;
            bootLimitPages <= r.lim;
            altVectorEn <= r.alt;
            partMode <= r.mode;
            activePart2 <= r.act;
            req.issue(r.k, {r.pg, r.hi, 9'h000}, {r.sp, 10'h000});
            `CHK("answer pulse", 1'b0, req.late)
            `CHK("allow", r.allow, rspAllow)
            if (r.why != 3'h7) `CHK("reason", r.why, rspReason)
            if (r.seg != 2'h3) `CHK("segment", r.seg, rspSegment)
            if (r.allow && r.k[1]) expCommits++;
        end
        `CHK("commits", expCommits, req.commits)
        @(posedge clk_sys);
        rst_b <= 1'b0;
        #1;
        `CHK("allow in reset", 1'b0, rspAllow)
        `CHK("segment in reset", 2'h0, rspSegment)
        @(posedge clk_sys);
        rst_b <= 1'b1;
        // first request at the first edge allowed after release
        req.issue(2'h1, 24'h001400, 24'h000000);
        `CHK("allow after reset", 1'b1, rspAllow)
        print_verdict();
    end
    initial begin
        #100us;
        failures++;
        print_verdict();
    end
endmodule
`default_nettype wire
